// ---- design/fieldbus_params.svh ----
`ifndef FIELDBUS_PARAMS_SVH
`define FIELDBUS_PARAMS_SVH

// register byte offsets
`define REG_CTRL 8'h00
`define REG_NODE 8'h04
`define REG_ACTIVE 8'h08
`define REG_SYNC 8'h0C
`define REG_STATUS 8'h10
`define REG_MASK 8'h14
`define REG_MAP 8'h18
`define REG_SII_ADDR 8'h1C
`define REG_SII_DATA 8'h20
`define REG_PDO_IDX 8'h24
`define REG_PDO_DATA 8'h28

// field positions
`define CTRL_BUS_BIT 0
`define CTRL_METHOD_LSB 4
`define CTRL_METHOD_MSB 7
`define CTRL_RESTART_BIT 31
`define NODE_MSB 6
`define ACTIVE_NODE_LSB 8
`define ACTIVE_NODE_MSB 14
`define ACTIVE_METHOD_LSB 16
`define ACTIVE_METHOD_MSB 19
`define SYNC_MODE_MSB 1
`define SYNC_UNITS_LSB 8
`define SYNC_UNITS_MSB 14

// reset values
`define BUS_SEL_RST 1'b1
`define METHOD_RST 4'h0
`define NODE_RST 7'h01
`define SYNC_UNITS_RST 7'h08

// cycle grid in 125 us steps
`define CYCLE_UNITS_MIN 7'h01
`define CYCLE_UNITS_MAX 7'h40

// status and mask bits
`define ST_CMD_REJ 0
`define ST_MBX_REJ 1
`define ST_CYC_REJ 2
`define ST_SII_WR 3
`define ST_SYNC 4
`define ST_W 5

// datagram command codes
`define CMD_AP_RD 8'h01
`define CMD_AP_WR 8'h02
`define CMD_FP_RD 8'h04
`define CMD_FP_WR 8'h05
`define CMD_BC_RD 8'h07
`define CMD_BC_WR 8'h08
`define CMD_LG_RD 8'h0A
`define CMD_LG_WR 8'h0B
`define CMD_AP_RMW 8'h0D
`define CMD_FP_RMW 8'h0E

// mailbox type and service codes
`define MBX_TYPE_COE 4'h3
`define COE_EMERGENCY 4'h1
`define COE_SDO_REQ 4'h2
`define COE_SDO_RSP 4'h3
`define COE_SDO_INFO 4'h8

// fixed channel roles, two bits each
`define MAP_SM_ROLES 8'hE4
`define MAP_FMMU_TARGETS 6'h24
`define MAP_FMMU_LSB 8

// timing
`define SYNC_STEP_NS 125000
`define CLK_PERIOD_NS 10

`endif

// ---- design/fieldbus_pkg.sv ----
package fieldbus_pkg;
  typedef enum logic [1:0] {
    SYNC_FREE_RUN,
    SYNC_DC,
    SYNC_SM2
  } sync_mode_e;
endpackage

// ---- design/sync_timer.sv ----
`timescale 1ns/1ps
`include "fieldbus_params.svh"
module sync_timer #(
  parameter int STEP_CYCLES = `SYNC_STEP_NS / `CLK_PERIOD_NS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire fieldbus_pkg::sync_mode_e mode,
  input wire logic [6:0] cycle_units,
  input wire logic enable,
  input wire logic sm2_event,
  output logic sync_pulse
);
  localparam int SW = $clog2(STEP_CYCLES + 1);

  generate
    if (STEP_CYCLES < 1) begin : g_bad
      $error("sync_timer: STEP_CYCLES must be at least 1");
    end
  endgenerate

  logic [SW-1:0] step_cnt;
  logic [6:0] unit_cnt;
  logic step_done;
  logic dc_run;

  assign dc_run = enable && (mode == fieldbus_pkg::SYNC_DC);
  assign step_done = (step_cnt == SW'(STEP_CYCLES - 1));

  // base 125 us tick
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      step_cnt <= '0;
    end else if (!dc_run || step_done) begin
      step_cnt <= '0;
    end else begin
      step_cnt <= step_cnt + SW'(1);
    end
  end

  // whole cycle made of cycle_units ticks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      unit_cnt <= '0;
    end else if (!dc_run) begin
      unit_cnt <= '0;
    end else if (step_done) begin
      unit_cnt <= (unit_cnt + 7'h01 >= cycle_units) ? 7'h00 : unit_cnt + 7'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_pulse <= 1'b0;
    end else if (enable && mode == fieldbus_pkg::SYNC_SM2) begin
      sync_pulse <= sm2_event;
    end else begin
      sync_pulse <= dc_run && step_done && (unit_cnt + 7'h01 >= cycle_units);
    end
  end
endmodule

// ---- design/fieldbus_slave_link_config.sv ----
`timescale 1ns/1ps
`include "fieldbus_params.svh"
// Summary of operation
// RULE1: sync manager 0 carries mailbox data in, 1 mailbox data out, 2 process data in and 3 process data out.
// RULE2: FMMU 0 maps the receive process data, FMMU 1 the transmit process data and FMMU 2 the mailbox status.
// RULE3: the ten supported read, write and read-modify-write datagrams addressed here are accepted.
// RULE4: the master must not use combined read-write datagrams, which this block refuses.
// RULE5: the CoE mailbox accepts emergency, SDO request, SDO response and SDO information services.
// RULE6: process data and remote process data sent through the mailbox are rejected.
// RULE7: the process data layout comes from a writable mapping table, not a fixed assignment.
// RULE8: sync is selectable between free run and distributed clock, with sync on sync manager 2 events too.
// RULE9: distributed clock cycles run from 125 us to 8 ms on a 125 us grid; other values are refused.
// RULE10: a 256-byte information store is readable by the master and never writable by it.
// RULE11: bus select 0 disables the fieldbus and hands control to a local selector, 1 (default) enables it, after restart.
// RULE12: the node number spans 0 to 127, defaults to 1 and takes effect after the next restart.
module fieldbus_slave_link_config #(
  parameter int STEP_CYCLES = `SYNC_STEP_NS / `CLK_PERIOD_NS,
  parameter int PDO_DEPTH = 8,
  parameter int SII_BYTES = 256
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic dg_valid,
  input wire logic [7:0] dg_cmd,
  input wire logic dg_addressed,
  output logic dg_accept,
  output logic dg_reject,
  input wire logic mbx_valid,
  input wire logic [3:0] mbx_type,
  input wire logic [3:0] mbx_service,
  output logic mbx_accept,
  output logic mbx_reject,
  input wire logic sii_rd,
  input wire logic sii_wr,
  input wire logic [7:0] sii_addr,
  output logic [7:0] sii_rdata,
  output logic sii_rvalid,
  input wire logic [$clog2(PDO_DEPTH)-1:0] pdo_sel,
  output logic [31:0] pdo_entry,
  input wire logic sm2_event,
  output logic sync_pulse,
  output logic fieldbus_enable,
  output logic [3:0] local_control_method_selector,
  output logic [6:0] station_node_number,
  output logic irq
);
  localparam int PW = $clog2(PDO_DEPTH);

  generate
    if (PDO_DEPTH < 2 || (1 << PW) != PDO_DEPTH) begin : g_bad_pdo
      $error("PDO_DEPTH must be a power of two, at least 2");
    end
    if (SII_BYTES != 256) begin : g_bad_sii
      $error("SII_BYTES must be 256 to match the 8-bit store address");
    end
  endgenerate

  // pending settings, active copies
  logic bus_sel_pend;
  logic [3:0] method_pend;
  logic [6:0] node_pend;
  logic bus_sel_act;
  logic [3:0] method_act;
  logic [6:0] node_act;
  fieldbus_pkg::sync_mode_e sync_mode;
  logic [6:0] cycle_units;
  logic [`ST_W-1:0] status;
  logic [`ST_W-1:0] mask;
  logic [7:0] sii_ptr;
  logic [7:0] sii_mem [SII_BYTES];
  logic [PW-1:0] pdo_ptr;
  logic [31:0] pdo_map [PDO_DEPTH];

  // bus pipeline
  logic wr_pend;
  logic rd_pend;
  logic [7:0] ph_addr;
  logic addr_ok;
  logic take;
  logic wr_en;
  logic [7:0] a;
  logic restart;
  logic cyc_ok;
  logic [`ST_W-1:0] events;
  logic sync_raw;

  function automatic logic cmd_supported(input logic [7:0] c);
    if (c == `CMD_AP_RD || c == `CMD_AP_WR || c == `CMD_FP_RD || c == `CMD_FP_WR) begin
      return 1'b1;
    end else if (c == `CMD_BC_RD || c == `CMD_BC_WR || c == `CMD_LG_RD || c == `CMD_LG_WR) begin
      return 1'b1;
    end else if (c == `CMD_AP_RMW || c == `CMD_FP_RMW) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction

  function automatic logic coe_service_ok(input logic [3:0] t, input logic [3:0] s);
    if (t != `MBX_TYPE_COE) begin
      return 1'b0;
    end else if (s == `COE_EMERGENCY || s == `COE_SDO_REQ || s == `COE_SDO_RSP) begin
      return 1'b1;
    end else begin
      return s == `COE_SDO_INFO;
    end
  endfunction

  assign addr_ok = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'b00);
  assign take = hsel && hready && htrans[1];
  assign wr_en = wr_pend;
  assign a = ph_addr;
  assign hreadyout = !rd_pend;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      ph_addr <= 8'h00;
    end else begin
      wr_pend <= take && hwrite && addr_ok;
      rd_pend <= take && !hwrite;
      if (take) begin
        ph_addr <= addr_ok ? haddr[7:0] : 8'hFF;
      end
    end
  end

  assign restart = wr_en && a == `REG_CTRL && hwdata[`CTRL_RESTART_BIT];
  assign cyc_ok = hwdata[`SYNC_UNITS_MSB:`SYNC_UNITS_LSB] >= `CYCLE_UNITS_MIN &&
                  hwdata[`SYNC_UNITS_MSB:`SYNC_UNITS_LSB] <= `CYCLE_UNITS_MAX &&
                  hwdata[`SYNC_MODE_MSB:0] != 2'b11;

  // pending settings written by software
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_sel_pend <= `BUS_SEL_RST;
      method_pend <= `METHOD_RST;
      node_pend <= `NODE_RST;
    end else if (wr_en && a == `REG_CTRL) begin
      bus_sel_pend <= hwdata[`CTRL_BUS_BIT];
      method_pend <= hwdata[`CTRL_METHOD_MSB:`CTRL_METHOD_LSB];
    end else if (wr_en && a == `REG_NODE) begin
      node_pend <= hwdata[`NODE_MSB:0]; // RULE12
    end
  end

  // active settings change only on restart
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_sel_act <= `BUS_SEL_RST; // RULE11
      method_act <= `METHOD_RST;
      node_act <= `NODE_RST; // RULE12
    end else if (restart) begin
      bus_sel_act <= bus_sel_pend; // RULE11
      method_act <= method_pend;
      node_act <= node_pend; // RULE12
    end
  end

  assign fieldbus_enable = bus_sel_act;
  assign station_node_number = node_act;
  assign local_control_method_selector = method_act;

  // sync configuration
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_mode <= fieldbus_pkg::SYNC_FREE_RUN;
      cycle_units <= `SYNC_UNITS_RST;
    end else if (wr_en && a == `REG_SYNC && cyc_ok) begin
      sync_mode <= fieldbus_pkg::sync_mode_e'(hwdata[`SYNC_MODE_MSB:0]); // RULE8
      cycle_units <= hwdata[`SYNC_UNITS_MSB:`SYNC_UNITS_LSB]; // RULE9
    end
  end

  sync_timer #(
    .STEP_CYCLES(STEP_CYCLES)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .mode(sync_mode),
    .cycle_units(cycle_units),
    .enable(bus_sel_act),
    .sm2_event(sm2_event),
    .sync_pulse(sync_raw)
  );
  assign sync_pulse = sync_raw;

  // datagram gate
  always_comb begin
    dg_accept = 1'b0;
    dg_reject = 1'b0;
    if (dg_valid && dg_addressed && bus_sel_act) begin
      dg_accept = cmd_supported(dg_cmd); // RULE3
      dg_reject = !cmd_supported(dg_cmd); // RULE4
    end
  end

  // mailbox gate
  always_comb begin
    mbx_accept = 1'b0;
    mbx_reject = 1'b0;
    if (mbx_valid && bus_sel_act) begin
      mbx_accept = coe_service_ok(mbx_type, mbx_service); // RULE5
      mbx_reject = !coe_service_ok(mbx_type, mbx_service); // RULE6
    end
  end

  // information store, loaded by software only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sii_ptr <= 8'h00;
    end else if (wr_en && a == `REG_SII_ADDR) begin
      sii_ptr <= hwdata[7:0];
    end else if (wr_en && a == `REG_SII_DATA) begin
      sii_ptr <= sii_ptr + 8'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < SII_BYTES; i++) begin
        sii_mem[i] <= 8'h00;
      end
    end else if (wr_en && a == `REG_SII_DATA) begin
      sii_mem[sii_ptr] <= hwdata[7:0];
    end
  end

  // master side: read only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sii_rdata <= 8'h00;
      sii_rvalid <= 1'b0;
    end else begin
      sii_rvalid <= sii_rd && !sii_wr && bus_sel_act; // RULE10
      if (sii_rd && !sii_wr && bus_sel_act) begin
        sii_rdata <= sii_mem[sii_addr]; // RULE10
      end
    end
  end

  // process data mapping table
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pdo_ptr <= '0;
    end else if (wr_en && a == `REG_PDO_IDX) begin
      pdo_ptr <= hwdata[PW-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < PDO_DEPTH; i++) begin
        pdo_map[i] <= 32'h00000000;
      end
    end else if (wr_en && a == `REG_PDO_DATA) begin
      pdo_map[pdo_ptr] <= hwdata; // RULE7
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pdo_entry <= 32'h00000000;
    end else begin
      pdo_entry <= pdo_map[pdo_sel]; // RULE7
    end
  end

  // events, sticky status, write one to clear
  always_comb begin
    events = '0;
    events[`ST_CMD_REJ] = dg_reject;
    events[`ST_MBX_REJ] = mbx_reject;
    events[`ST_CYC_REJ] = wr_en && a == `REG_SYNC && !cyc_ok; // RULE9
    events[`ST_SII_WR] = sii_wr && bus_sel_act; // RULE10
    events[`ST_SYNC] = sync_raw;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status <= '0;
    end else if (wr_en && a == `REG_STATUS) begin
      status <= (status & ~hwdata[`ST_W-1:0]) | events;
    end else begin
      status <= status | events;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask <= '0;
    end else if (wr_en && a == `REG_MASK) begin
      mask <= hwdata[`ST_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

  // read data, one wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (rd_pend) begin
      hrdata <= 32'h00000000;
      if (a == `REG_CTRL) begin
        hrdata[`CTRL_BUS_BIT] <= bus_sel_pend;
        hrdata[`CTRL_METHOD_MSB:`CTRL_METHOD_LSB] <= method_pend;
      end else if (a == `REG_NODE) begin
        hrdata[`NODE_MSB:0] <= node_pend;
      end else if (a == `REG_ACTIVE) begin
        hrdata[`CTRL_BUS_BIT] <= bus_sel_act;
        hrdata[`ACTIVE_NODE_MSB:`ACTIVE_NODE_LSB] <= node_act;
        hrdata[`ACTIVE_METHOD_MSB:`ACTIVE_METHOD_LSB] <= method_act;
      end else if (a == `REG_SYNC) begin
        hrdata[`SYNC_MODE_MSB:0] <= sync_mode;
        hrdata[`SYNC_UNITS_MSB:`SYNC_UNITS_LSB] <= cycle_units;
      end else if (a == `REG_STATUS) begin
        hrdata[`ST_W-1:0] <= status;
      end else if (a == `REG_MASK) begin
        hrdata[`ST_W-1:0] <= mask;
      end else if (a == `REG_MAP) begin
        hrdata[7:0] <= `MAP_SM_ROLES; // RULE1
        hrdata[`MAP_FMMU_LSB+5:`MAP_FMMU_LSB] <= `MAP_FMMU_TARGETS; // RULE2
      end else if (a == `REG_SII_ADDR) begin
        hrdata[7:0] <= sii_ptr;
      end else if (a == `REG_SII_DATA) begin
        hrdata[7:0] <= sii_mem[sii_ptr];
      end else if (a == `REG_PDO_IDX) begin
        hrdata[PW-1:0] <= pdo_ptr;
      end else if (a == `REG_PDO_DATA) begin
        hrdata <= pdo_map[pdo_ptr];
      end
    end
  end
endmodule

// ---- testbench/fieldbus_slave_link_config_sva.sv ----
`timescale 1ns/1ps
`include "fieldbus_params.svh"
module fieldbus_link_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic dg_valid,
  input wire logic [7:0] dg_cmd,
  input wire logic dg_addressed,
  input wire logic dg_accept,
  input wire logic dg_reject,
  input wire logic mbx_valid,
  input wire logic [3:0] mbx_type,
  input wire logic [3:0] mbx_service,
  input wire logic mbx_accept,
  input wire logic mbx_reject,
  input wire logic sii_rd,
  input wire logic sii_wr,
  input wire logic sii_rvalid,
  input wire logic sync_pulse,
  input wire logic fieldbus_enable,
  input wire logic [6:0] station_node_number
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic wr_ctrl;
  wire dg_on = dg_valid && dg_addressed && fieldbus_enable;
  wire dg_known = dg_cmd inside {8'h01, 8'h02, 8'h04, 8'h05, 8'h07, 8'h08, 8'h0A, 8'h0B, 8'h0D, 8'h0E};
  wire mbx_known = mbx_type == 4'h3 && mbx_service inside {4'h1, 4'h2, 4'h3, 4'h8};
  wire sii_go = sii_rd && !sii_wr && fieldbus_enable;
  wire restart_seen = wr_ctrl && hwdata[31];
  // ctrl write in its data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ctrl <= 1'b0;
    end else if (hready) begin
      wr_ctrl <= hsel && htrans[1] && hwrite && haddr[7:0] == `REG_CTRL;
    end
  end
  sequence s_rd_req;
    hsel && hready && htrans[1] && !hwrite;
  endsequence
  sequence s_rd_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  property p_rd_wait;
    s_rd_req |=> s_rd_wait;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
  property p_wr_zero;
    hsel && hready && htrans[1] && hwrite |=> hreadyout;
  endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("write stalled");
  property p_dg_ok;
    dg_on && dg_known |-> dg_accept && !dg_reject;
  endproperty
  a_dg_ok: assert property (p_dg_ok) else $error("datagram not accepted");
  property p_dg_rw;
    dg_on && !dg_known |-> dg_reject && !dg_accept;
  endproperty
  a_dg_rw: assert property (p_dg_rw) else $error("datagram not rejected");
  property p_bus_off;
    !fieldbus_enable |-> !(dg_accept || dg_reject || mbx_accept || mbx_reject);
  endproperty
  a_bus_off: assert property (p_bus_off) else $error("traffic answered with bus off");
  property p_mbx_ok;
    mbx_valid && fieldbus_enable && mbx_known |-> mbx_accept && !mbx_reject;
  endproperty
  a_mbx_ok: assert property (p_mbx_ok) else $error("mailbox not accepted");
  property p_mbx_bad;
    mbx_valid && fieldbus_enable && !mbx_known |-> mbx_reject && !mbx_accept;
  endproperty
  a_mbx_bad: assert property (p_mbx_bad) else $error("mailbox not rejected");
  property p_sii_rv;
    sii_rd && !sii_wr && fieldbus_enable |=> sii_rvalid;
  endproperty
  a_sii_rv: assert property (p_sii_rv) else $error("store read lost");
  property p_sii_cause;
    sii_rvalid |-> $past(sii_go);
  endproperty
  a_sii_cause: assert property (p_sii_cause) else $error("store valid without read");
  property p_sync_off;
    !fieldbus_enable && !$past(fieldbus_enable) |-> !sync_pulse;
  endproperty
  a_sync_off: assert property (p_sync_off) else $error("sync with bus off");
  property p_restart;
    $changed(station_node_number) || $changed(fieldbus_enable) |-> $past(restart_seen);
  endproperty
  a_restart: assert property (p_restart) else $error("setting changed without restart");
endmodule

// ---- testbench/fieldbus_master_model.sv ----
`timescale 1ns/1ps
module fieldbus_master_model (
  input wire logic hclk,
  output logic dg_valid,
  output logic [7:0] dg_cmd,
  output logic dg_addressed,
  output logic mbx_valid,
  output logic [3:0] mbx_type,
  output logic [3:0] mbx_service,
  output logic sii_rd,
  output logic sii_wr,
  output logic [7:0] sii_addr,
  output logic sm2_event
);
  initial begin
    {dg_valid, dg_addressed, mbx_valid, sii_rd, sii_wr, sm2_event} = 6'h00;
    {dg_cmd, mbx_type, mbx_service, sii_addr} = 24'h000000;
  end
  // unsupported codes go out only when a test wants the refusal
  task automatic offer(input logic [7:0] c, input logic a, input logic [7:0] mt, input logic m);
    @(posedge hclk);
    dg_valid <= !m;
    dg_cmd <= c;
    dg_addressed <= a;
    mbx_valid <= m;
    {mbx_type, mbx_service} <= mt;
  endtask
  task automatic sii(input logic r, input logic w, input logic [7:0] a);
    @(posedge hclk);
    sii_rd <= r;
    sii_wr <= w;
    sii_addr <= a;
  endtask
  task automatic sm2;
    @(posedge hclk);
    sm2_event <= 1'b1;
  endtask
  // released code, type and address lines show garbage, not the last value; dg_addressed keeps its last value
  task automatic idle;
    @(posedge hclk);
    dg_valid <= 1'b0;
    dg_cmd <= ~dg_cmd;
    mbx_valid <= 1'b0;
    {mbx_type, mbx_service} <= ~{mbx_type, mbx_service};
    {sii_rd, sii_wr, sm2_event} <= 3'h0;
    sii_addr <= ~sii_addr;
  endtask
endmodule

// ---- testbench/fieldbus_slave_link_config_tb.sv ----
`timescale 1ns/1ps
`include "fieldbus_params.svh"
module fieldbus_slave_link_config_tb;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, dg_valid, dg_addressed, dg_accept, dg_reject, ok;
  logic mbx_valid, mbx_accept, mbx_reject, sii_rd, sii_wr, sii_rvalid, sm2_event, sync_pulse, fieldbus_enable, irq;
  logic [1:0] htrans;
  logic [2:0] hsize, pdo_sel;
  logic [3:0] mbx_type, mbx_service, local_control_method_selector;
  logic [6:0] station_node_number;
  logic [7:0] dg_cmd, sii_addr, sii_rdata;
  logic [31:0] haddr, hwdata, hrdata, pdo_entry, rdv;
  int mismatches, cmp_count, cyc, n;
  fieldbus_slave_link_config #(.STEP_CYCLES(4)) dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .dg_valid, .dg_cmd, .dg_addressed, .dg_accept,
    .dg_reject, .mbx_valid, .mbx_type, .mbx_service, .mbx_accept, .mbx_reject, .sii_rd, .sii_wr, .sii_addr,
    .sii_rdata, .sii_rvalid, .pdo_sel, .pdo_entry, .sm2_event, .sync_pulse, .fieldbus_enable,
    .local_control_method_selector, .station_node_number, .irq);
  fieldbus_master_model m_u (.hclk, .dg_valid, .dg_cmd, .dg_addressed, .mbx_valid, .mbx_type, .mbx_service,
    .sii_rd, .sii_wr, .sii_addr, .sm2_event);
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rdv = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h00000000);
    chk(rdv, e);
  endtask
  task automatic period(input int e);
    n = 0;
    while (sync_pulse !== 1'b1 && n < 600) begin
      @(posedge hclk);
      n++;
    end
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (sync_pulse !== 1'b1 && n < 600);
    chk(32'(n), 32'(e));
  endtask
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      tally_and_finish;
    end
  end
  initial begin
    {hresetn, hsel, hwrite} = 3'h0;
    {htrans, pdo_sel, hsize} = {2'h0, 3'h0, 3'h2};
    {haddr, hwdata} = 64'h0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rd(`REG_CTRL, 32'h00000001);
    rd(`REG_ACTIVE, 32'h00000101);
    rd(`REG_SYNC, 32'h00000800);
    rd(`REG_MAP, 32'h000024E4);
    rd(8'h40, 32'h00000000);
    chk(32'(hresp), 32'h0);
    $display("test reset values done");
    for (int c = 0; c < 16; c++) begin
      m_u.offer(8'(c), 1'b1, 8'h00, 1'b0);
      #1;
      ok = c inside {1, 2, 4, 5, 7, 8, 10, 11, 13, 14};
      chk(32'({dg_accept, dg_reject}), 32'({ok, !ok}));
    end
    m_u.offer(8'h01, 1'b0, 8'h00, 1'b0);
    #1;
    chk(32'({dg_accept, dg_reject}), 32'h0);
    m_u.idle();
    chk(32'(irq), 32'h0);
    ahb(1'b1, `REG_MASK, 32'h00000001);
    @(posedge hclk);
    #1;
    chk(32'(irq), 32'h1);
    ahb(1'b1, `REG_STATUS, 32'h0000003F);
    rd(`REG_STATUS, 32'h00000000);
    chk(32'(irq), 32'h0);
    $display("test datagrams done");
    for (int t = 2; t < 4; t++) begin
      for (int s = 0; s < 16; s++) begin
        m_u.offer(8'h00, 1'b0, {4'(t), 4'(s)}, 1'b1);
        #1;
        ok = t == 3 && s inside {1, 2, 3, 8};
        chk(32'({mbx_accept, mbx_reject}), 32'({ok, !ok}));
      end
    end
    m_u.idle();
    ahb(1'b1, `REG_STATUS, 32'h0000003F);
    ahb(1'b1, `REG_SII_ADDR, 32'h000000FF);
    ahb(1'b1, `REG_SII_DATA, 32'h000000A5);
    m_u.sii(1'b1, 1'b0, 8'hFF);
    m_u.idle();
    #1;
    chk(32'({sii_rvalid, sii_rdata}), 32'h1A5);
    m_u.sii(1'b0, 1'b1, 8'hFF);
    m_u.sii(1'b1, 1'b0, 8'hFF);
    m_u.idle();
    #1;
    chk(32'({sii_rvalid, sii_rdata}), 32'h1A5);
    rd(`REG_STATUS, 32'h00000008);
    $display("test store done");
    ahb(1'b1, `REG_SYNC, 32'h00000101);
    period(4);
    ahb(1'b1, `REG_SYNC, 32'h00004001);
    period(256);
    ahb(1'b1, `REG_STATUS, 32'h0000003F);
    ahb(1'b1, `REG_SYNC, 32'h00004101);
    ahb(1'b1, `REG_SYNC, 32'h00000001);
    ahb(1'b1, `REG_SYNC, 32'h00000103);
    rd(`REG_SYNC, 32'h00004001);
    rd(`REG_STATUS, 32'h00000004);
    ahb(1'b1, `REG_SYNC, 32'h00000802);
    m_u.sm2();
    m_u.idle();
    #1;
    chk(32'(sync_pulse), 32'h1);
    ahb(1'b1, `REG_SYNC, 32'h00000800);
    repeat (40) begin
      @(posedge hclk);
      chk(32'(sync_pulse), 32'h0);
    end
    $display("test sync done");
    ahb(1'b1, `REG_PDO_IDX, 32'h00000007);
    ahb(1'b1, `REG_PDO_DATA, 32'h60400010);
    pdo_sel <= 3'h7;
    repeat (2) @(posedge hclk);
    chk(pdo_entry, 32'h60400010);
    $display("test mapping done");
    ahb(1'b1, `REG_SYNC, 32'h00000101);
    ahb(1'b1, `REG_NODE, 32'h0000007F);
    ahb(1'b1, `REG_CTRL, 32'h00000050);
    chk(32'({fieldbus_enable, station_node_number}), 32'h81);
    ahb(1'b1, `REG_CTRL, 32'h80000050);
    rd(`REG_ACTIVE, 32'h00057F00);
    chk(32'({fieldbus_enable, local_control_method_selector, station_node_number}), 32'h2FF);
    m_u.offer(8'h01, 1'b1, 8'h00, 1'b0);
    m_u.sii(1'b1, 1'b0, 8'h00);
    #1;
    chk(32'({dg_accept, dg_reject}), 32'h0);
    m_u.idle();
    #1;
    chk(32'(sii_rvalid), 32'h0);
    ahb(1'b1, `REG_NODE, 32'h00000000);
    ahb(1'b1, `REG_CTRL, 32'h00000001);
    ahb(1'b1, `REG_CTRL, 32'h80000001);
    rd(`REG_ACTIVE, 32'h00000001);
    $display("test restart done");
    tally_and_finish;
  end
endmodule
bind fieldbus_slave_link_config fieldbus_link_checker chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hreadyout, .dg_valid, .dg_cmd, .dg_addressed, .dg_accept, .dg_reject, .mbx_valid, .mbx_type,
  .mbx_service, .mbx_accept, .mbx_reject, .sii_rd, .sii_wr, .sii_rvalid, .sync_pulse, .fieldbus_enable,
  .station_node_number);
